// ===== pkg/spm_pkg.sv
// ============================================================
// Purpose: Shared constants for the register area and page selection
// Assumes: 8-bit register bus, addresses 8 bits wide
// Notes: Field positions and reset values are named here only
package spm_pkg;
   // ==========================================================
   // Addresses
   localparam logic [7:0] SPM_CTRL0_ADDR = 8'h8f;
   localparam logic [7:0] SPM_SYS_PAGE_ADDR = 8'hbf;
   // Default address of the generic module page register
   localparam logic [7:0] SPM_UNIT_PAGE_ADDR = 8'hb1;
   // ==========================================================
   // Field layout of every page register
   localparam int SPM_PAGE_LSB = 0;
   localparam int SPM_PAGE_W = 3;
   localparam int SPM_SLOT_SEL_LSB = 4;
   localparam int SPM_SLOT_SEL_W = 2;
   localparam int SPM_PAGE_OPER_LSB = 6;
   localparam int SPM_PAGE_OPER_W = 2;
   localparam int SPM_SLOTS = 4;
   // Map-select bit position in control register 0
   localparam int SPM_MAP_BIT = 0;
   // ==========================================================
   // Page operation codes
   localparam logic [1:0] SPM_OPER_SAVE = 2'h2;
   localparam logic [1:0] SPM_OPER_RESTORE = 2'h3;
   // Reset values
   localparam logic [7:0] SPM_REG_RESET = 8'h00;
   localparam logic [2:0] SPM_PAGE_RESET = 3'h0;
endpackage

// ===== hdl/spm_page_unit.sv
// Purpose: One page register with four storage slots
// Assumes: Write strobe is a single-cycle pulse on core_clk_i
// Notes: Slots live in flip-flops; page read data is registered
`timescale 1ns/100ps
module spm_page_unit
   import spm_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   // Write side
   input wire logic wr_i,
   input wire logic [7:0] wdata_i,
   // Current page
   output logic [SPM_PAGE_W-1:0] page_o
);
   // ==========================================================
   // State
   logic [SPM_PAGE_W-1:0] page;
   logic [SPM_PAGE_W-1:0] next_page;
   logic [SPM_PAGE_W-1:0] slot [SPM_SLOTS];
   logic [SPM_PAGE_W-1:0] next_slot [SPM_SLOTS];
   logic [SPM_PAGE_OPER_W-1:0] page_operation; // Operation of this write
   logic [SPM_SLOT_SEL_W-1:0] storage_select; // Target slot of this write

   assign page_operation = wdata_i[SPM_PAGE_OPER_LSB +: SPM_PAGE_OPER_W];
   assign storage_select = wdata_i[SPM_SLOT_SEL_LSB +: SPM_SLOT_SEL_W];
   assign page_o = page;

   // Next page and slot contents from the write
   always_comb
   begin
      next_page = page;
      next_slot = slot;
      if (wr_i)
      begin
         // Save current page, then take the written one
         if (page_operation == SPM_OPER_SAVE)
         begin
            next_slot[storage_select] = page;
            next_page = wdata_i[SPM_PAGE_LSB +: SPM_PAGE_W];
         end
         // Restore from slot, ignore written page bits
         else if (page_operation == SPM_OPER_RESTORE)
            next_page = slot[storage_select];
         // Plain load, slots untouched
         else
            next_page = wdata_i[SPM_PAGE_LSB +: SPM_PAGE_W];
      end
   end

   // Register page and slots
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         page <= SPM_PAGE_RESET;
         for (int i = 0; i < SPM_SLOTS; i++)
            slot[i] <= SPM_PAGE_RESET;
      end
      else
      begin
         page <= next_page;
         slot <= next_slot;
      end
   end

   // Restore brings back what a save stored
   restore_value_a: assert property (@(posedge core_clk_i)
      disable iff (reset_i)
      wr_i && page_operation == SPM_OPER_RESTORE
      |=> page == $past(slot[storage_select]))
      else $error("restore did not load slot");
endmodule

// ===== hdl/spm_sfr_map.sv
// ============================================================
// ============================================================
// Purpose: Register-area selection and page registers of the core
// Assumes: Core gives one-cycle write/read strobes with an address
// Notes: Read data is registered, valid the cycle after the read
`timescale 1ns/100ps
module spm_sfr_map
   import spm_pkg::*;
#(
   parameter logic [7:0] UNIT_PAGE_ADDR = SPM_UNIT_PAGE_ADDR
)
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   // Core register access
   input wire logic [7:0] addr_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o,
   output logic rvalid_o,
   // Area and page state
   output logic map_select_o,
   output logic [SPM_PAGE_W-1:0] sys_page_o,
   output logic [SPM_PAGE_W-1:0] unit_page_o,
   // Decode result for CPU and system control registers
   output logic cpu_area_o,
   output logic sysctl_area_o
);
   // ==========================================================
   // Decode
   logic map_select; // Map-select bit
   logic next_map_select;
   logic hit_ctl0; // Control register 0 hit
   logic hit_scu; // System page register hit
   logic hit_mod; // Module page register hit
   logic [SPM_PAGE_W-1:0] sys_page; // Active system unit page
   logic [SPM_PAGE_W-1:0] unit_page; // Active module page
   // Write fields, used by the checks below
   logic [SPM_PAGE_OPER_W-1:0] wr_oper; // Operation field
   logic [SPM_SLOT_SEL_W-1:0] wr_slot; // Slot field
   logic [SPM_PAGE_W-1:0] wr_page; // Page field
   logic [7:0] next_rdata;
   logic next_cpu_area;
   logic next_sysctl_area;

   // Control register 0 is reachable in both areas
   assign hit_ctl0 = addr_i == SPM_CTRL0_ADDR;
   // System unit page register only in standard area
   assign hit_scu = addr_i == SPM_SYS_PAGE_ADDR && !map_select;
   assign hit_mod = addr_i == UNIT_PAGE_ADDR && !map_select;
   // Field split of the write data
   assign wr_oper = wdata_i[SPM_PAGE_OPER_LSB +: SPM_PAGE_OPER_W];
   assign wr_slot = wdata_i[SPM_SLOT_SEL_LSB +: SPM_SLOT_SEL_W];
   assign wr_page = wdata_i[SPM_PAGE_LSB +: SPM_PAGE_W];

   // ==========================================================
   // Page units
   // System unit page, reached only in the standard area
   spm_page_unit u_sys_page
   (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .wr_i(wr_i && hit_scu),
      .wdata_i(wdata_i),
      .page_o(sys_page)
   );

   // Generic module page, same layout and slot behaviour
   spm_page_unit u_unit_page
   (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .wr_i(wr_i && hit_mod),
      .wdata_i(wdata_i),
      .page_o(unit_page)
   );

   // ==========================================================
   // Next values for map bit, read data and area flags
   always_comb
   begin
      next_map_select = map_select;
      if (wr_i && hit_ctl0)
         next_map_select = wdata_i[SPM_MAP_BIT];
      next_rdata = SPM_REG_RESET;
      if (rd_i)
      begin
         // Upper seven bits of control register 0 read zero
         if (hit_ctl0)
            next_rdata[SPM_MAP_BIT] = map_select;
         // Only page bits return; op and slot bits read zero
         else if (hit_scu)
            next_rdata[SPM_PAGE_LSB +: SPM_PAGE_W] = sys_page;
         else if (hit_mod)
            next_rdata[SPM_PAGE_LSB +: SPM_PAGE_W] = unit_page;
      end
      // CPU registers decode regardless of map-select
      next_cpu_area = 1'b1;
      next_sysctl_area = !next_map_select;
   end

   // Register state and outputs
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         map_select <= 1'b0;
         rdata_o <= SPM_REG_RESET;
         rvalid_o <= 1'b0;
         map_select_o <= 1'b0;
         sys_page_o <= SPM_PAGE_RESET;
         unit_page_o <= SPM_PAGE_RESET;
         cpu_area_o <= 1'b1;
         sysctl_area_o <= 1'b1;
      end
      else
      begin
         map_select <= next_map_select;
         rdata_o <= next_rdata;
         rvalid_o <= rd_i;
         map_select_o <= next_map_select;
         sys_page_o <= sys_page;
         unit_page_o <= unit_page;
         cpu_area_o <= next_cpu_area;
         sysctl_area_o <= next_sysctl_area;
      end
   end

   // ==========================================================
   // Checks
   // Read of the system page returns the page held at the read
   page_read_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
      rd_i && hit_scu |=> rdata_o == {5'h00, $past(sys_page)})
      else $error("page read wrong");
   // Save shows the written page at the output two edges later
   save_load_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
      wr_i && hit_scu && wr_oper == SPM_OPER_SAVE
      |=> ##1 sys_page_o == $past(wr_page, 2))
      else $error("save did not load new page");
   // Codes 00 and 01 load the module page directly
   plain_load_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
      wr_i && hit_mod && !wr_oper[1]
      |=> ##1 unit_page_o == $past(wr_page, 2))
      else $error("plain load failed");
   // Restore shows the stored slot, not the written page bits
   restore_ignore_a: assert property (@(posedge core_clk_i)
      disable iff (reset_i)
      wr_i && hit_scu && wr_oper == SPM_OPER_RESTORE
      |=> ##1 sys_page_o == $past(u_sys_page.slot[wr_slot], 2))
      else $error("restore check");
   // Both pages come out of reset at page zero
   reset_zero_a: assert property (@(posedge core_clk_i)
      $past(reset_i)
      |-> sys_page_o == SPM_PAGE_RESET && unit_page_o == SPM_PAGE_RESET)
      else $error("page not zero after reset");
   // Operation, slot and bit 3 always read as zero
   write_fields_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
      rd_i && (hit_scu || hit_mod) |=> rdata_o[7:3] == 5'h00)
      else $error("write-only bits read back");
   // Control register 0 takes the map-select bit
   map_bit_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
      wr_i && hit_ctl0 |=> map_select_o == $past(wdata_i[SPM_MAP_BIT]))
      else $error("map bit not written");
   // Control register 0 reads the bit, upper bits zero
   ctl_read_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
      rd_i && hit_ctl0 |=> rdata_o == {7'h00, $past(map_select)})
      else $error("control register read wrong");
   // Mapped area hides system control, CPU stays decoded
   sysctl_gate_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
      map_select_o |-> !sysctl_area_o && cpu_area_o)
      else $error("area decode wrong");
   // CPU registers decode in both areas
   cpu_area_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
      cpu_area_o)
      else $error("cpu area not decoded");
   // System page ignores writes in the mapped area
   mapped_block_a: assert property (@(posedge core_clk_i)
      disable iff (reset_i)
      map_select && wr_i && addr_i == SPM_SYS_PAGE_ADDR
      |=> $stable(u_sys_page.page))
      else $error("page written in mapped area");
   // Module page ignores writes in the mapped area
   mapped_unit_a: assert property (@(posedge core_clk_i)
      disable iff (reset_i)
      map_select && wr_i && addr_i == UNIT_PAGE_ADDR
      |=> $stable(u_unit_page.page))
      else $error("module page written in mapped area");
   // Read answer strobe follows the read by one edge
   read_strobe_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
      rd_i |=> rvalid_o)
      else $error("read answer missing");
   // Read data return to zero without a read
   idle_read_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
      !rd_i |=> rdata_o == SPM_REG_RESET)
      else $error("read data not cleared");
   save_c: cover property (@(posedge core_clk_i)
      wr_i && hit_scu && wr_oper == SPM_OPER_SAVE);
   restore_c: cover property (@(posedge core_clk_i)
      wr_i && hit_mod && wr_oper == SPM_OPER_RESTORE);
   mapped_c: cover property (@(posedge core_clk_i) map_select_o);
   plain_c: cover property (@(posedge core_clk_i)
      wr_i && hit_mod && !wr_oper[1]);
   unmap_c: cover property (@(posedge core_clk_i)
      map_select_o ##1 !map_select_o);
endmodule

// ===== test/test_sfr_page_map_select.sv
// Purpose: Self-checking bench for register-area and page selection
// Assumes: One-cycle strobes driven on the falling edge of core_clk_i
// Notes: Read data is sampled one falling edge after the read strobe
`timescale 1ns/100ps
module test_sfr_page_map_select
   import spm_pkg::*;
;
   // =========================================================
   // Signals
   logic core_clk_i = 1'b0; // 250 MHz core clock
   logic reset_i = 1'b1; // Synchronous reset
   logic [7:0] addr_i = 8'h00; // Register address
   logic wr_i = 1'b0; // Write strobe
   logic rd_i = 1'b0; // Read strobe
   logic [7:0] wdata_i = 8'h00; // Write data
   logic [7:0] rdata_o; // Read data
   logic rvalid_o; // Read answer strobe
   logic map_select_o; // Area select
   logic [2:0] sys_page_o; // System unit page
   logic [2:0] unit_page_o; // Module page
   logic cpu_area_o; // CPU decode
   logic sysctl_area_o; // System control decode
   int error_cnt = 0; // Mismatches
   int n_checks = 0; // Comparisons
   localparam logic [7:0] BF = SPM_SYS_PAGE_ADDR;
   localparam logic [7:0] B1 = SPM_UNIT_PAGE_ADDR;
   // =========================================================
   // Clock and device
   always #2 core_clk_i = ~core_clk_i;
   spm_sfr_map i_spm_sfr_map (.core_clk_i(core_clk_i), .reset_i(reset_i),
      .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i),
      .rdata_o(rdata_o), .rvalid_o(rvalid_o), .map_select_o(map_select_o),
      .sys_page_o(sys_page_o), .unit_page_o(unit_page_o),
      .cpu_area_o(cpu_area_o), .sysctl_area_o(sysctl_area_o));
   // =========================================================
   // Shared tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
         error_cnt++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk_i);
      addr_i = a; wdata_i = d; wr_i = 1'b1;
      @(negedge core_clk_i);
      wr_i = 1'b0;
      @(negedge core_clk_i); // Let registered outputs settle
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge core_clk_i);
      addr_i = a; rd_i = 1'b1;
      @(negedge core_clk_i);
      rd_i = 1'b0;
      chk({7'h00, rvalid_o}, 8'h01);
      chk(rdata_o, exp);
   endtask
   function automatic logic [7:0] pg(input logic [7:0] a);
      return {5'h00, (a == BF) ? sys_page_o : unit_page_o};
   endfunction
   // =========================================================
   // Scenarios
   task automatic test_reset();
      rd(SPM_CTRL0_ADDR, 8'h00);
      rd(BF, SPM_REG_RESET);
      rd(B1, SPM_REG_RESET);
      chk({6'h00, cpu_area_o, sysctl_area_o}, 8'h03);
   endtask
   task automatic test_save_restore(input logic [7:0] a);
      for (int s = 0; s < SPM_SLOTS; s++)
      begin
         wr(a, {5'h00, 3'(s + 1)});
         wr(a, {SPM_OPER_SAVE, 2'(s), 4'h0});
         rd(a, 8'h00);
      end
      for (int s = SPM_SLOTS - 1; s >= 0; s--)
      begin
         wr(a, {SPM_OPER_RESTORE, 2'(s), 4'h7});
         rd(a, 8'(s + 1));
         chk(pg(a), 8'(s + 1));
      end
   endtask
   task automatic test_plain_load(input logic [7:0] a);
      wr(a, 8'h4e);
      rd(a, 8'h06);
      chk(pg(a), 8'h06);
      wr(a, 8'h3d);
      rd(a, 8'h05);
      wr(a, {SPM_OPER_RESTORE, 2'h0, 4'h0});
      rd(a, 8'h01);
   endtask
   task automatic test_map_select();
      wr(SPM_CTRL0_ADDR, 8'hff);
      rd(SPM_CTRL0_ADDR, 8'h01);
      chk({6'h00, cpu_area_o, sysctl_area_o}, 8'h02);
      chk({7'h00, map_select_o}, 8'h01);
      wr(BF, 8'h07);
      rd(BF, 8'h00);
      rd(8'h55, 8'h00);
      wr(SPM_CTRL0_ADDR, 8'h00);
      chk({6'h00, cpu_area_o, sysctl_area_o}, 8'h03);
      rd(BF, 8'h01);
      chk(pg(BF), 8'h01);
   endtask
   // =========================================================
   // Verdict
   task automatic complete_run();
      $display("checks=%0d errors=%0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Watchdog cuts a hang short
   initial
   begin
      #100000;
      error_cnt++;
      complete_run();
   end
   // Main sequence
   initial
   begin
      repeat (12) @(negedge core_clk_i);
      reset_i = 1'b0;
      test_reset();
      test_save_restore(BF);
      test_save_restore(B1);
      test_plain_load(BF);
      test_plain_load(B1);
      test_map_select();
      complete_run();
   end
endmodule
